// [hdl/asx_pkg.sv]
package asx_pkg;

  localparam logic [7:0]  OPC_PREFIX_Y   = 8'h18;
  localparam logic [7:0]  OPC_ADD16_IMD  = 8'hC3;
  localparam logic [7:0]  OPC_ADD16_DIR  = 8'hD3;
  localparam logic [7:0]  OPC_ADD16_EXD  = 8'hF3;
  localparam logic [7:0]  OPC_ADD16_IDX  = 8'hE3;
  localparam logic [7:0]  OPC_AND_A_IMD  = 8'h84;
  localparam logic [7:0]  OPC_AND_A_DIR  = 8'h94;
  localparam logic [7:0]  OPC_AND_A_EXD  = 8'hB4;
  localparam logic [7:0]  OPC_AND_A_IDX  = 8'hA4;
  localparam logic [7:0]  OPC_AND_B_IMD  = 8'hC4;
  localparam logic [7:0]  OPC_AND_B_DIR  = 8'hD4;
  localparam logic [7:0]  OPC_AND_B_EXD  = 8'hF4;
  localparam logic [7:0]  OPC_AND_B_IDX  = 8'hE4;
  localparam logic [7:0]  OPC_SHL_A      = 8'h48;
  localparam logic [7:0]  OPC_SHL_B      = 8'h58;
  localparam logic [7:0]  OPC_SHL_EXD    = 8'h78;
  localparam logic [7:0]  OPC_SHL_IDX    = 8'h68;
  localparam logic [7:0]  OPC_SHL_D      = 8'h05;

  localparam logic [15:0] DUMMY_ADDR     = 16'hFFFF;
  localparam logic [7:0]  DIRECT_PAGE    = 8'h00;

  localparam int          CC_S           = 7;
  localparam int          CC_X           = 6;
  localparam int          CC_H           = 5;
  localparam int          CC_I           = 4;
  localparam int          CC_N           = 3;
  localparam int          CC_Z           = 2;
  localparam int          CC_V           = 1;
  localparam int          CC_C           = 0;

  localparam logic [15:0] RST_PC         = 16'h0000;
  localparam logic [15:0] RST_INDEX      = 16'h0000;
  localparam logic [7:0]  RST_ACC        = 8'h00;
  localparam logic [7:0]  RST_CC         = 8'hD0;

  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_PC         = 8'h08;
  localparam logic [7:0]  REG_DACC       = 8'h0C;
  localparam logic [7:0]  REG_IX         = 8'h10;
  localparam logic [7:0]  REG_IY         = 8'h14;
  localparam logic [7:0]  REG_CC         = 8'h18;
  localparam int          CTRL_RUN       = 0;
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_ILL       = 1;

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_OP    = 11'h002,
    S_OP2   = 11'h004,
    S_INH   = 11'h008,
    S_B1    = 11'h010,
    S_B2    = 11'h020,
    S_IDX   = 11'h040,
    S_RD_H  = 11'h080,
    S_RD_L  = 11'h100,
    S_DUMMY = 11'h200,
    S_WR    = 11'h400
  } asx_state_type;

  typedef enum logic [2:0] {
    K_ADD16, K_AND, K_SHL, K_SHLD, K_ILL
  } asx_kind_type;

  typedef enum logic [2:0] {
    M_IMD, M_DIR, M_EXD, M_IDX, M_INH
  } asx_mode_type;

  typedef struct packed {
    asx_kind_type kind;
    asx_mode_type mode;
    logic         sel_b;
    logic         use_y;
  } asx_dec_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  wdata;
  } asx_mem_type;

  typedef struct packed {
    logic [15:0] res;
    logic [7:0]  cc;
  } asx_alu_res_type;

  function automatic asx_dec_type asx_decode(input logic [7:0] opc,
                                             input logic       ypre);
    asx_dec_type d;
    d = '{kind: K_ILL, mode: M_INH, sel_b: 1'b0, use_y: ypre};
    case (opc)
      OPC_ADD16_IMD: d = '{K_ADD16, M_IMD, 1'b0, ypre};
      OPC_ADD16_DIR: d = '{K_ADD16, M_DIR, 1'b0, ypre};
      OPC_ADD16_EXD: d = '{K_ADD16, M_EXD, 1'b0, ypre};
      OPC_ADD16_IDX: d = '{K_ADD16, M_IDX, 1'b0, ypre};
      OPC_AND_A_IMD: d = '{K_AND, M_IMD, 1'b0, ypre};
      OPC_AND_A_DIR: d = '{K_AND, M_DIR, 1'b0, ypre};
      OPC_AND_A_EXD: d = '{K_AND, M_EXD, 1'b0, ypre};
      OPC_AND_A_IDX: d = '{K_AND, M_IDX, 1'b0, ypre};
      OPC_AND_B_IMD: d = '{K_AND, M_IMD, 1'b1, ypre};
      OPC_AND_B_DIR: d = '{K_AND, M_DIR, 1'b1, ypre};
      OPC_AND_B_EXD: d = '{K_AND, M_EXD, 1'b1, ypre};
      OPC_AND_B_IDX: d = '{K_AND, M_IDX, 1'b1, ypre};
      OPC_SHL_A:     d = '{K_SHL, M_INH, 1'b0, ypre};
      OPC_SHL_B:     d = '{K_SHL, M_INH, 1'b1, ypre};
      OPC_SHL_EXD:   d = '{K_SHL, M_EXD, 1'b0, ypre};
      OPC_SHL_IDX:   d = '{K_SHL, M_IDX, 1'b0, ypre};
      OPC_SHL_D:     d = '{K_SHLD, M_INH, 1'b0, ypre};
      default:       d.kind = K_ILL;
    endcase
    // the y prefix only qualifies indexed forms
    if (ypre && d.mode != M_IDX) begin
      d.kind = K_ILL;
    end
    return d;
  endfunction

endpackage

// [hdl/asx_alu.sv]
`timescale 1ns/1ns
module asx_alu (
  input  asx_pkg::asx_kind_type    kind,
  input  asx_pkg::asx_mode_type    mode,
  input  logic                     sel_b,
  input  logic [7:0]               acc_a,
  input  logic [7:0]               acc_b,
  input  logic [15:0]              opnd,
  input  logic [7:0]               cc_in,
  output asx_pkg::asx_alu_res_type res
);
  import asx_pkg::*;

  logic [7:0]  x;
  logic [7:0]  sh8;
  logic [7:0]  r8;
  logic [15:0] d;
  logic [15:0] r16;
  logic [16:0] sum;

  always_comb begin
    x   = sel_b ? acc_b : acc_a;
    sh8 = (mode == M_INH) ? x : opnd[7:0];
    d   = {acc_a, acc_b};
    r8  = 8'h00;
    r16 = 16'h0000;
    sum = {1'b0, d} + {1'b0, opnd};
    res = '{res: 16'h0000, cc: cc_in};
    case (kind)
      K_ADD16: begin
        res.res      = sum[15:0];
        res.cc[CC_N] = sum[15];
        res.cc[CC_Z] = (sum[15:0] == 16'h0000);
        res.cc[CC_V] = (d[15] == opnd[15]) && (sum[15] != d[15]);
        res.cc[CC_C] = sum[16];
      end
      K_AND: begin
        r8           = x & opnd[7:0];
        res.res      = {8'h00, r8};
        res.cc[CC_N] = r8[7];
        res.cc[CC_Z] = (r8 == 8'h00);
        res.cc[CC_V] = 1'b0;
      end
      K_SHL: begin
        r8           = {sh8[6:0], 1'b0};
        res.res      = {8'h00, r8};
        res.cc[CC_C] = sh8[7];
        res.cc[CC_N] = r8[7];
        res.cc[CC_Z] = (r8 == 8'h00);
        res.cc[CC_V] = r8[7] ^ sh8[7];
      end
      K_SHLD: begin
        r16          = {d[14:0], 1'b0};
        res.res      = r16;
        res.cc[CC_C] = d[15];
        res.cc[CC_N] = r16[15];
        res.cc[CC_Z] = (r16 == 16'h0000);
        res.cc[CC_V] = r16[15] ^ d[15];
      end
      default: res.res = 16'h0000;
    endcase
  end

endmodule // asx_alu

// [hdl/asx_exec.sv]
`timescale 1ns/1ns
module asx_exec (
  input  logic                 ref_clk,
  input  logic                 rst_n,
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [7:0]           paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  output asx_pkg::asx_mem_type mem_bus,
  input  logic [7:0]           mem_rdata
);
  import asx_pkg::*;

  asx_state_type   state_r;
  asx_state_type   state_nxt;
  asx_dec_type     dec_r;
  asx_dec_type     dec_nxt;
  asx_mem_type     mem_r;
  asx_mem_type     mem_nxt;
  asx_alu_res_type alu_res;
  logic [7:0]      acc_a_r;
  logic [7:0]      acc_a_nxt;
  logic [7:0]      acc_b_r;
  logic [7:0]      acc_b_nxt;
  logic [7:0]      cc_r;
  logic [7:0]      cc_nxt;
  logic [7:0]      tmp_r;
  logic [7:0]      tmp_nxt;
  logic [15:0]     pc_r;
  logic [15:0]     pc_nxt;
  logic [15:0]     ix_r;
  logic [15:0]     ix_nxt;
  logic [15:0]     iy_r;
  logic [15:0]     iy_nxt;
  logic [15:0]     ea_r;
  logic [15:0]     ea_nxt;
  logic            run_r;
  logic            run_nxt;
  logic            ill_r;
  logic            ill_nxt;
  logic [31:0]     prdata_r;
  logic [31:0]     prdata_nxt;
  logic            commit;
  logic            finish;
  logic            wr_en;
  logic            rd_en;
  logic [15:0]     idx_base;

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_PC) ||
           (a == REG_DACC) || (a == REG_IX) || (a == REG_IY) ||
           (a == REG_CC);
  endfunction

  asx_alu asx_alu_inst (
    .kind  (dec_r.kind),
    .mode  (dec_r.mode),
    .sel_b (dec_r.sel_b),
    .acc_a (acc_a_r),
    .acc_b (acc_b_r),
    .opnd  ({tmp_r, mem_rdata}),
    .cc_in (cc_r),
    .res   (alu_res)
  );

  always_comb begin
    state_nxt  = state_r;
    dec_nxt    = dec_r;
    acc_a_nxt  = acc_a_r;
    acc_b_nxt  = acc_b_r;
    cc_nxt     = cc_r;
    tmp_nxt    = tmp_r;
    pc_nxt     = pc_r;
    ix_nxt     = ix_r;
    iy_nxt     = iy_r;
    ea_nxt     = ea_r;
    run_nxt    = run_r;
    ill_nxt    = ill_r;
    prdata_nxt = prdata_r;
    commit     = 1'b0;
    finish     = 1'b0;
    wr_en      = psel & penable & pwrite;
    rd_en      = psel & ~penable & ~pwrite;
    idx_base   = dec_r.use_y ? iy_r : ix_r;

    // cpu state is only writable while halted
    if (wr_en) begin
      if (paddr == REG_CTRL) begin
        run_nxt = pwdata[CTRL_RUN];
      end else if (paddr == REG_STATUS) begin
        if (pwdata[STAT_ILL]) begin
          ill_nxt = 1'b0;
        end
      end else if (paddr == REG_PC && state_r == S_IDLE) begin
        pc_nxt = pwdata[15:0];
      end else if (paddr == REG_DACC && state_r == S_IDLE) begin
        acc_a_nxt = pwdata[15:8];
        acc_b_nxt = pwdata[7:0];
      end else if (paddr == REG_IX && state_r == S_IDLE) begin
        ix_nxt = pwdata[15:0];
      end else if (paddr == REG_IY && state_r == S_IDLE) begin
        iy_nxt = pwdata[15:0];
      end else if (paddr == REG_CC && state_r == S_IDLE) begin
        cc_nxt = pwdata[7:0];
      end
    end

    case (state_r)
      S_IDLE: begin
        if (run_r) begin
          state_nxt = S_OP;
        end
      end
      S_OP, S_OP2: begin
        pc_nxt = pc_r + 16'h0001;
        if (state_r == S_OP && mem_rdata == OPC_PREFIX_Y) begin
          state_nxt = S_OP2;
        end else begin
          dec_nxt = asx_decode(mem_rdata, state_r == S_OP2);
          if (dec_nxt.kind == K_ILL) begin
            // unknown opcode halts; set beats a same-cycle clear
            ill_nxt   = 1'b1;
            run_nxt   = 1'b0;
            state_nxt = S_IDLE;
          end else if (dec_nxt.mode == M_INH) begin
            state_nxt = S_INH;
          end else begin
            state_nxt = S_B1;
          end
        end
      end
      S_INH: begin
        commit = 1'b1;
        if (dec_r.kind == K_SHLD) begin
          state_nxt = S_DUMMY;
        end else begin
          finish = 1'b1;
        end
      end
      S_B1: begin
        pc_nxt = pc_r + 16'h0001;
        case (dec_r.mode)
          M_IMD: begin
            if (dec_r.kind == K_ADD16) begin
              tmp_nxt   = mem_rdata;
              state_nxt = S_B2;
            end else begin
              commit = 1'b1;
              finish = 1'b1;
            end
          end
          M_DIR: begin
            ea_nxt    = {DIRECT_PAGE, mem_rdata};
            state_nxt = S_RD_H;
          end
          M_EXD: begin
            tmp_nxt   = mem_rdata;
            state_nxt = S_B2;
          end
          default: begin
            ea_nxt    = idx_base + {8'h00, mem_rdata};
            state_nxt = S_IDX;
          end
        endcase
      end
      S_B2: begin
        pc_nxt = pc_r + 16'h0001;
        if (dec_r.mode == M_IMD) begin
          commit    = 1'b1;
          state_nxt = S_DUMMY;
        end else begin
          ea_nxt    = {tmp_r, mem_rdata};
          state_nxt = S_RD_H;
        end
      end
      S_IDX: state_nxt = S_RD_H;
      S_RD_H: begin
        if (dec_r.kind == K_ADD16) begin
          tmp_nxt   = mem_rdata;
          state_nxt = S_RD_L;
        end else if (dec_r.kind == K_SHL) begin
          commit    = 1'b1;
          state_nxt = S_DUMMY;
        end else begin
          commit = 1'b1;
          finish = 1'b1;
        end
      end
      S_RD_L: begin
        commit    = 1'b1;
        state_nxt = S_DUMMY;
      end
      S_DUMMY: begin
        if (dec_r.kind == K_SHL) begin
          state_nxt = S_WR;
        end else begin
          finish = 1'b1;
        end
      end
      S_WR:    finish = 1'b1;
      default: state_nxt = S_IDLE;
    endcase

    if (finish) begin
      state_nxt = run_nxt ? S_OP : S_IDLE;
    end

    if (commit) begin
      cc_nxt = alu_res.cc;
      if (dec_r.kind == K_ADD16 || dec_r.kind == K_SHLD) begin
        acc_a_nxt = alu_res.res[15:8];
        acc_b_nxt = alu_res.res[7:0];
      end else if (dec_r.kind == K_SHL && dec_r.mode != M_INH) begin
        tmp_nxt = alu_res.res[7:0];
      end else if (dec_r.sel_b) begin
        acc_b_nxt = alu_res.res[7:0];
      end else begin
        acc_a_nxt = alu_res.res[7:0];
      end
    end

    // bus outputs are registered from the next state
    mem_nxt.rw    = (state_nxt != S_WR);
    mem_nxt.wdata = (state_nxt == S_WR) ? tmp_nxt : 8'h00;
    case (state_nxt)
      S_OP, S_OP2, S_INH, S_B1, S_B2: mem_nxt.addr = pc_nxt;
      S_RD_H, S_WR:                   mem_nxt.addr = ea_nxt;
      S_RD_L:                         mem_nxt.addr = ea_nxt + 16'h0001;
      default:                        mem_nxt.addr = DUMMY_ADDR;
    endcase

    if (rd_en) begin
      if (paddr == REG_CTRL) begin
        prdata_nxt = {31'h0, run_r};
      end else if (paddr == REG_STATUS) begin
        prdata_nxt = {30'h0, ill_r, state_r != S_IDLE};
      end else if (paddr == REG_PC) begin
        prdata_nxt = {16'h0000, pc_r};
      end else if (paddr == REG_DACC) begin
        prdata_nxt = {16'h0000, acc_a_r, acc_b_r};
      end else if (paddr == REG_IX) begin
        prdata_nxt = {16'h0000, ix_r};
      end else if (paddr == REG_IY) begin
        prdata_nxt = {16'h0000, iy_r};
      end else if (paddr == REG_CC) begin
        prdata_nxt = {24'h000000, cc_r};
      end else begin
        prdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r  <= S_IDLE;
      dec_r    <= '{kind: K_ILL, mode: M_INH, sel_b: 1'b0, use_y: 1'b0};
      mem_r    <= '{addr: DUMMY_ADDR, rw: 1'b1, wdata: 8'h00};
      acc_a_r  <= RST_ACC;
      acc_b_r  <= RST_ACC;
      cc_r     <= RST_CC;
      tmp_r    <= 8'h00;
      pc_r     <= RST_PC;
      ix_r     <= RST_INDEX;
      iy_r     <= RST_INDEX;
      ea_r     <= 16'h0000;
      run_r    <= 1'b0;
      ill_r    <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      state_r  <= state_nxt;
      dec_r    <= dec_nxt;
      mem_r    <= mem_nxt;
      acc_a_r  <= acc_a_nxt;
      acc_b_r  <= acc_b_nxt;
      cc_r     <= cc_nxt;
      tmp_r    <= tmp_nxt;
      pc_r     <= pc_nxt;
      ix_r     <= ix_nxt;
      iy_r     <= iy_nxt;
      ea_r     <= ea_nxt;
      run_r    <= run_nxt;
      ill_r    <= ill_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign mem_bus = mem_r;
  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~reg_mapped(paddr);

  // checking helpers
  logic [15:0] d_now;
  logic [15:0] m_now;
  logic [15:0] chk_res;
  logic        chk_carry;
  logic        chk_ovf;
  logic [3:0]  cc_hi;
  logic        cc_carry;
  logic        a_msb;
  logic [7:0]  a_shl;
  logic [7:0]  m_shl;
  logic [15:0] d_shl;
  logic        add_c;
  logic        shl_c;
  assign d_now     = {acc_a_r, acc_b_r};
  assign m_now     = {tmp_r, mem_rdata};
  assign {chk_carry, chk_res} = {1'b0, d_now} + {1'b0, m_now};
  assign chk_ovf   = (d_now[15] == m_now[15]) && (chk_res[15] != d_now[15]);
  assign cc_hi     = cc_r[7:4];
  assign cc_carry  = cc_r[CC_C];
  assign a_msb     = acc_a_r[7];
  assign a_shl     = {acc_a_r[6:0], 1'b0};
  assign m_shl     = {mem_rdata[6:0], 1'b0};
  assign d_shl     = {d_now[14:0], 1'b0};
  assign add_c     = commit && dec_r.kind == K_ADD16;
  assign shl_c     = commit && (dec_r.kind == K_SHL || dec_r.kind == K_SHLD);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_add16_sum;
    add_c |=> d_now == $past(chk_res);
  endproperty
  a_add16_sum: assert property (p_add16_sum)
    else $error("16-bit add result wrong");

  property p_add16_nz;
    add_c |=> cc_r[CC_N] == acc_a_r[7] && cc_r[CC_Z] == (d_now == 16'h0000)
              && cc_hi == $past(cc_hi);
  endproperty
  a_add16_nz: assert property (p_add16_nz)
    else $error("16-bit add N, Z or upper flags wrong");

  property p_add16_vc;
    add_c |=> cc_r[CC_C] == $past(chk_carry) && cc_r[CC_V] == $past(chk_ovf);
  endproperty
  a_add16_vc: assert property (p_add16_vc)
    else $error("16-bit add V or C wrong");

  property p_add16_y_addr;
    state_r == S_OP2 && mem_rdata == OPC_ADD16_IDX |=> state_r == S_B1
      ##1 state_r == S_IDX
      ##1 (state_r == S_RD_H && mem_bus.addr ==
           $past(iy_r, 2) + {8'h00, $past(mem_rdata, 2)});
  endproperty
  a_add16_y_addr: assert property (p_add16_y_addr)
    else $error("y-indexed 16-bit add address wrong");

  property p_add16_imd_len;
    state_r == S_OP && mem_rdata == OPC_ADD16_IMD |=> state_r == S_B1
      ##1 state_r == S_B2
      ##1 (state_r == S_DUMMY && mem_bus.addr == DUMMY_ADDR && mem_bus.rw)
      ##1 (state_r == S_OP || state_r == S_IDLE);
  endproperty
  a_add16_imd_len: assert property (p_add16_imd_len)
    else $error("immediate 16-bit add not four cycles");

  property p_and_flags;
    commit && dec_r.kind == K_AND |=> !cc_r[CC_V]
      && cc_carry == $past(cc_carry)
      && cc_r[CC_N] == (dec_r.sel_b ? acc_b_r[7] : acc_a_r[7])
      && cc_r[CC_Z] == ((dec_r.sel_b ? acc_b_r : acc_a_r) == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags)
    else $error("AND flags wrong");

  property p_and_imd_len;
    state_r == S_OP && mem_rdata == OPC_AND_A_IMD |=> state_r == S_B1
      ##1 (state_r == S_OP || state_r == S_IDLE);
  endproperty
  a_and_imd_len: assert property (p_and_imd_len)
    else $error("immediate AND not two cycles");

  property p_shl_mem;
    state_r == S_RD_H && dec_r.kind == K_SHL |=> tmp_r == $past(m_shl)
      && cc_carry == $past(mem_rdata[7]);
  endproperty
  a_shl_mem: assert property (p_shl_mem)
    else $error("byte shift left result or carry wrong");

  property p_shl_v;
    shl_c |=> cc_r[CC_V] == (cc_r[CC_N] ^ cc_r[CC_C]);
  endproperty
  a_shl_v: assert property (p_shl_v)
    else $error("shift left overflow not N xor C");

  property p_shl_a;
    state_r == S_OP && mem_rdata == OPC_SHL_A |=> state_r == S_INH
      ##1 (acc_a_r == $past(a_shl) && cc_carry == $past(a_msb));
  endproperty
  a_shl_a: assert property (p_shl_a)
    else $error("accumulator A shift left wrong");

  property p_mem_write;
    state_r == S_WR |-> !mem_bus.rw && $past(state_r) == S_DUMMY
      && $past(state_r, 2) == S_RD_H
      && mem_bus.addr == $past(mem_bus.addr, 2);
  endproperty
  a_mem_write: assert property (p_mem_write)
    else $error("memory shift left write sequence wrong");

  property p_shld;
    commit && dec_r.kind == K_SHLD |=> d_now == $past(d_shl)
      && cc_carry == $past(a_msb) && cc_r[CC_N] == acc_a_r[7]
      && cc_r[CC_Z] == (d_now == 16'h0000);
  endproperty
  a_shld: assert property (p_shld)
    else $error("double shift left wrong");

  property p_rw_low;
    !mem_bus.rw |-> state_r == S_WR;
  endproperty
  a_rw_low: assert property (p_rw_low)
    else $error("read/write low outside write cycle");

  c_add16:  cover property (add_c);
  c_mem_wr: cover property (state_r == S_WR);
  c_y_mode: cover property (state_r == S_OP2 ##1 state_r == S_B1);
  c_ill:    cover property ($rose(ill_r));

endmodule // asx_exec

// [verification/asx_mem.sv]
`timescale 1ns/1ns
module asx_mem (
  input  wire logic            ref_clk,
  input  asx_pkg::asx_mem_type mem_bus,
  output logic [7:0]           mem_rdata
);
  import asx_pkg::*;
  logic [7:0] m [0:65535];
  int         nwr = 0;
  // data lines released on writes: show inverse
  assign mem_rdata = mem_bus.rw ? m[mem_bus.addr] : ~m[mem_bus.addr];
  initial for (int i = 0; i < 65536; i++) m[i] = 8'hA5;
  always @(posedge ref_clk) begin
    if (!mem_bus.rw) begin
      m[mem_bus.addr] <= mem_bus.wdata;
      nwr <= nwr + 1;
    end
  end
endmodule // asx_mem

// [verification/tb_asx_exec.sv]
`timescale 1ns/1ns
module tb_asx_exec;
  import asx_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, mem_rdata;
  logic [31:0] pwdata, prdata, q;
  asx_mem_type mem_bus;
  int          fails = 0;
  int          num_checks = 0;
  asx_exec asx_exec_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_bus(mem_bus),
    .mem_rdata(mem_rdata)
  );
  asx_mem asx_mem_inst (
    .ref_clk(ref_clk), .mem_bus(mem_bus), .mem_rdata(mem_rdata)
  );
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // four program bytes, first byte at a
  task automatic ld(input logic [15:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) asx_mem_inst.m[a + i] = v[31 - 8*i -: 8];
  endtask
  // program ends on an unsupported opcode, which halts the block
  task automatic run(input logic [15:0] pc, input logic [15:0] d,
                     input logic [7:0] cc, input logic [15:0] ed,
                     input logic [7:0] ecc);
    apb(1'b1, REG_PC, {16'h0000, pc});
    apb(1'b1, REG_DACC, {16'h0000, d});
    apb(1'b1, REG_CC, {24'h000000, cc});
    apb(1'b1, REG_CTRL, 32'h00000001);
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, REG_CTRL, 32'h0);
      if (q[0] === 1'b0) break;
    end
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h00000002);
    apb(1'b0, REG_DACC, 32'h0);
    chk(q, {16'h0000, ed});
    apb(1'b0, REG_CC, 32'h0);
    chk(q, {24'h000000, ecc});
    apb(1'b1, REG_STATUS, 32'h00000002);
  endtask
  task automatic t_regs;
    apb(1'b0, REG_CC, 32'h0);
    chk(q, 32'h000000D0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h00000001);
    chk(q, 32'h00000000);
  endtask
  task automatic t_add_imm;
    ld(16'h0100, 32'hC3000100);
    run(16'h0100, 16'h7FFF, 8'hF0, 16'h8000, 8'hFA);
  endtask
  task automatic t_add_ext;
    ld(16'h0110, 32'hF3020000);
    ld(16'h0200, 32'h12340000);
    run(16'h0110, 16'hEDCC, 8'hD0, 16'h0000, 8'hD5);
  endtask
  task automatic t_and_dir;
    ld(16'h0120, 32'hD4400000);
    ld(16'h0040, 32'h3C000000);
    run(16'h0120, 16'h55F0, 8'hD3, 16'h5530, 8'hD1);
  endtask
  task automatic t_shl_mem;
    int n;
    apb(1'b1, REG_IY, 32'h00000300);
    ld(16'h0130, 32'h18680500);
    ld(16'h0305, 32'hC0000000);
    n = asx_mem_inst.nwr;
    run(16'h0130, 16'h1234, 8'hD0, 16'h1234, 8'hD9);
    chk({24'h0, asx_mem_inst.m[16'h0305]}, 32'h00000080);
    chk(asx_mem_inst.nwr - n, 32'h00000001);
  endtask
  task automatic t_shl_d;
    ld(16'h0140, 32'h05000000);
    run(16'h0140, 16'h4000, 8'hD0, 16'h8000, 8'hDA);
  endtask
  task automatic t_shl_a;
    ld(16'h0150, 32'h48000000);
    run(16'h0150, 16'h80FF, 8'hD0, 16'h00FF, 8'hD7);
  endtask
  // AND A immediate, shift B, then a y-indexed 16-bit add back to back
  task automatic t_and_shl_add_y;
    apb(1'b1, REG_IY, 32'h00000400);
    ld(16'h0160, 32'h840F5818);
    ld(16'h0164, 32'hE3100000);
    ld(16'h0410, 32'h80010000);
    run(16'h0160, 16'hF344, 8'hD0, 16'h8389, 8'hD8);
    apb(1'b0, REG_PC, 32'h0);
    chk(q, 32'h00000167);
  endtask
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_add_imm;
    t_add_ext;
    t_and_dir;
    t_shl_mem;
    t_shl_d;
    t_shl_a;
    t_and_shl_add_y;
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule // tb_asx_exec
